// file: hdl/fss_pkg.sv
/*
  Constants, types and field layouts for the flexible-disk function sequencer.
  Assumes a single 40 MHz clock domain and a synchronous, active-high reset.
*/
// How it works
// R1 - Empty buffer raises transfer request per word
// R2 - Empty buffer leaves sector buffer untouched
// R3 - Word count set by mode, length, density
// R4 - After last word: status presented, done set
// R5 - Interrupt pulse on done when enabled
// R6 - Write sector clears status, requests sector
// R7 - Second request fetches the track address
// R8 - Density mismatch reports error and terminates
// R9 - Write buffer plus two CRC bytes
// R10 - Read sector clears status, requests both addresses
// R11 - Illegal track ends function with error
// R12 - Sector not found gives code 70 octal
// R13 - Find data mark, fill buffer from disk
// R14 - Read good only on zero CRC residue
// R15 - CRC failure sets bit 11, code 200
// R16 - Deleted mark sets status bit 5
// R17 - Every function ends status then done
// R18 - Mode one code 100 only finishes
// R19 - Mode two code 100 checks key I
// R20 - Density init writes mark, zeros, CRC
// R21 - Init covers tracks 0-76, 26 sectors
// R22 - Host clears done before each command
package fss_pkg;

  // ----------------------------------------------------------------
  // Command word and host interface
  // ----------------------------------------------------------------
  localparam int           WORD_W       = 12;
  localparam int           CMD_FUNC_LSB = 1;
  localparam int           CMD_W8_BIT   = 5;
  localparam int           CMD_DD_BIT   = 8;
  localparam logic [2:0]   FN_EMPTY     = 3'h1;
  localparam logic [2:0]   FN_WRITE     = 3'h2;
  localparam logic [2:0]   FN_READ      = 3'h3;
  localparam logic [2:0]   FN_DENSITY   = 3'h4;
  localparam logic [7:0]   KEY_BYTE     = 8'h49;
  localparam logic [6:0]   LAST_TRACK   = 7'h4c;
  localparam logic [4:0]   LAST_SECTOR  = 5'h1a;
  localparam logic [4:0]   FIRST_SECTOR = 5'h01;

  // ----------------------------------------------------------------
  // Transfer sizes
  // ----------------------------------------------------------------
  localparam logic [8:0]   CNT_64       = 9'h040;
  localparam logic [8:0]   CNT_128      = 9'h080;
  localparam logic [8:0]   CNT_256      = 9'h100;

  // ----------------------------------------------------------------
  // Error/status bits and error codes
  // ----------------------------------------------------------------
  localparam int           ES_DELETED   = 5;
  localparam int           ES_DENSITY   = 6;
  localparam int           ES_DENS_ERR  = 7;
  localparam int           ES_MODE2     = 8;
  localparam int           ES_CRC_ERR   = 11;
  localparam logic [7:0]   EC_TRACK     = 8'h20;
  localparam logic [7:0]   EC_NOT_FOUND = 8'h38;
  localparam logic [7:0]   EC_HEADER    = 8'h60;
  localparam logic [7:0]   EC_CRC       = 8'h80;
  localparam logic [7:0]   EC_DENSITY   = 8'ha0;
  localparam logic [7:0]   EC_KEY       = 8'ha8;
  localparam logic [15:0]  CRC_INIT     = 16'hffff;
  localparam logic [15:0]  CRC_POLY     = 16'h1021;

  // ----------------------------------------------------------------
  // Register map, byte addresses on the bus
  // ----------------------------------------------------------------
  localparam logic [7:0]   REG_CTRL     = 8'h00;
  localparam logic [7:0]   REG_FLAGS    = 8'h04;
  localparam logic [7:0]   REG_ERRCODE  = 8'h08;
  localparam logic [7:0]   REG_ESTAT    = 8'h0c;
  localparam int           CTRL_MODE2   = 0;
  localparam int           CTRL_IE      = 1;

  // ----------------------------------------------------------------
  // Drive results and request carrier
  // ----------------------------------------------------------------
  localparam logic [1:0]   DRV_FOUND    = 2'h0;
  localparam logic [1:0]   DRV_NOTFOUND = 2'h1;

  typedef struct packed {
    logic       write;
    logic       dd;
    logic [6:0] track;
    logic [4:0] sector;
  } fss_drv_req_type;

  typedef enum logic [3:0] {
    ST_IDLE, ST_EB_LOAD, ST_EB_WAIT, ST_SEC_REQ, ST_TRK_REQ, ST_KEY_REQ,
    ST_CHECK, ST_FIND, ST_READ, ST_RD_CHECK, ST_WRITE, ST_FINISH
  } fss_state_type;

endpackage

// file: hdl/fss_sequencer.sv
/*
  Function sequencer of a flexible-disk controller: empty buffer, write sector,
  read sector and set media density, with transfer-request/done/error flags.
  Assumes host instruction strobes are one-cycle pulses synchronous to CLOCK_IN,
  a drive engine that seeks, finds sectors and streams bytes, and a classic
  Wishbone master for the control and status registers.
*/
module fss_sequencer
  import fss_pkg::*;
(
  input  wire logic              CLOCK_IN,
  input  wire logic              RST_IN,
  input  wire logic              LOAD_CMD_IN,
  input  wire logic [WORD_W-1:0] CMD_WORD_IN,
  input  wire logic              XFER_WR_IN,
  input  wire logic              XFER_RD_IN,
  input  wire logic [WORD_W-1:0] XFER_DATA_IN,
  input  wire logic              TREQ_TEST_IN,
  input  wire logic              DONE_TEST_IN,
  output logic      [WORD_W-1:0] IFACE_WORD_OUT,
  output logic                   TREQ_OUT,
  output logic                   DONE_OUT,
  output logic                   ERROR_OUT,
  output logic                   INT_REQ_OUT,
  input  wire logic              DRV_DENSITY_IN,
  output logic                   DRV_REQ_VALID_OUT,
  output fss_drv_req_type        DRV_REQ_OUT,
  input  wire logic              DRV_ACK_IN,
  input  wire logic [1:0]        DRV_RESULT_IN,
  input  wire logic              DRV_RD_VALID_IN,
  input  wire logic [7:0]        DRV_RD_DATA_IN,
  input  wire logic              DRV_RD_DELETED_IN,
  output logic                   DRV_WR_VALID_OUT,
  output logic      [7:0]        DRV_WR_DATA_OUT,
  input  wire logic              DRV_WR_READY_IN,
  input  wire logic              WB_CYC_IN,
  input  wire logic              WB_STB_IN,
  input  wire logic              WB_WE_IN,
  input  wire logic [7:0]        WB_ADR_IN,
  input  wire logic [3:0]        WB_SEL_IN,
  input  wire logic [31:0]       WB_DAT_IN,
  output logic      [31:0]       WB_DAT_OUT,
  output logic                   WB_ACK_OUT
);

  fss_state_type   state_q;
  logic [2:0]      func_q;
  logic            w8_q;
  logic            dd_q;
  logic            init_q;
  logic [4:0]      sector_q;
  logic [6:0]      track_q;
  logic [8:0]      cnt_q;
  logic [15:0]     crc_q;
  logic [WORD_W-1:0] est_q;
  logic [7:0]      errcode_q;
  logic            treq_set_q;
  logic            done_set_q;
  logic            err_set_q;
  logic            treq_q;
  logic            done_q;
  logic            error_q;
  logic            int_q;
  logic            mode2_q;
  logic            ie_q;
  logic [WORD_W-1:0] iface_q;
  logic            drv_valid_q;
  fss_drv_req_type drv_req_q;
  logic            wr_valid_q;
  logic [7:0]      wr_data_q;
  logic            ack_q;
  logic [31:0]     rdata_q;
  logic [WORD_W-1:0] buf_q [256];
  logic [8:0]      words;
  logic [8:0]      sect_bytes;
  logic            buf_we;
  logic [7:0]      buf_idx;
  logic [7:0]      wr_byte;
  logic [WORD_W-1:0] status_word;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[15] ^ d[i]) begin
        r = {r[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Transfer sizes and derived words
  // ----------------------------------------------------------------
  always_comb begin
    if (mode2_q && dd_q) begin
      words = w8_q ? CNT_256 : CNT_128;  // see R3
    end else begin
      words = w8_q ? CNT_128 : CNT_64;   // see R3
    end
    sect_bytes = dd_q ? CNT_256 : CNT_128;
    status_word = est_q;
    status_word[ES_MODE2] = mode2_q;
    status_word[ES_DENSITY] = mode2_q & DRV_DENSITY_IN;
  end

  // The buffer is only ever written by a disk read, so empty buffer and
  // write sector cannot disturb it.
  assign buf_we  = (state_q == ST_READ) && DRV_RD_VALID_IN && (cnt_q != 9'h000) && (cnt_q <= sect_bytes); // see R2, R9
  assign buf_idx = 8'(cnt_q - 9'h001);
  assign wr_byte = (cnt_q < sect_bytes) ? (init_q ? 8'h00 : buf_q[cnt_q[7:0]][7:0]) :
                   (cnt_q == sect_bytes) ? crc_q[15:8] : crc_q[7:0];

  // ----------------------------------------------------------------
  // Sector buffer
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_IN) begin
    if (buf_we) begin
      buf_q[buf_idx] <= {4'h0, DRV_RD_DATA_IN};  // see R13
    end
  end

  // ----------------------------------------------------------------
  // Function sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      state_q     <= ST_IDLE;
      func_q      <= 3'h0;
      w8_q        <= 1'b0;
      dd_q        <= 1'b0;
      init_q      <= 1'b0;
      sector_q    <= 5'h00;
      track_q     <= 7'h00;
      cnt_q       <= 9'h000;
      crc_q       <= CRC_INIT;
      est_q       <= '0;
      errcode_q   <= 8'h00;
      treq_set_q  <= 1'b0;
      done_set_q  <= 1'b0;
      err_set_q   <= 1'b0;
      iface_q     <= '0;
      drv_valid_q <= 1'b0;
      drv_req_q   <= '0;
      wr_valid_q  <= 1'b0;
      wr_data_q   <= 8'h00;
    end else begin
      treq_set_q <= 1'b0;
      done_set_q <= 1'b0;
      err_set_q  <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (LOAD_CMD_IN) begin
            func_q <= CMD_WORD_IN[CMD_FUNC_LSB +: 3];
            w8_q   <= CMD_WORD_IN[CMD_W8_BIT];
            dd_q   <= CMD_WORD_IN[CMD_DD_BIT];
            init_q <= 1'b0;
            cnt_q  <= 9'h000;
            case (CMD_WORD_IN[CMD_FUNC_LSB +: 3])
              FN_EMPTY: state_q <= ST_EB_LOAD;
              FN_WRITE, FN_READ: begin
                est_q      <= '0;       // see R6, R10
                treq_set_q <= 1'b1;     // see R6, R10
                state_q    <= ST_SEC_REQ;
              end
              FN_DENSITY: begin
                if (mode2_q) begin
                  treq_set_q <= 1'b1;   // see R19
                  state_q    <= ST_KEY_REQ;
                end else begin
                  state_q <= ST_FINISH; // see R18
                end
              end
              default: state_q <= ST_FINISH;
            endcase
          end
        end
        ST_EB_LOAD: begin
          iface_q    <= buf_q[cnt_q[7:0]] & (w8_q ? 12'h0ff : 12'hfff);
          treq_set_q <= 1'b1;           // see R1
          state_q    <= ST_EB_WAIT;
        end
        ST_EB_WAIT: begin
          if (XFER_RD_IN) begin
            cnt_q   <= cnt_q + 9'h001;
            state_q <= (cnt_q + 9'h001 == words) ? ST_FINISH : ST_EB_LOAD;  // see R4
          end
        end
        ST_SEC_REQ: begin
          if (XFER_WR_IN) begin
            sector_q   <= XFER_DATA_IN[4:0];
            treq_set_q <= 1'b1;         // see R7
            state_q    <= ST_TRK_REQ;
          end
        end
        ST_TRK_REQ: begin
          if (XFER_WR_IN) begin
            track_q <= XFER_DATA_IN[6:0];
            if (XFER_DATA_IN > {5'h00, LAST_TRACK}) begin
              errcode_q <= EC_TRACK;    // see R11
              err_set_q <= 1'b1;
              state_q   <= ST_FINISH;
            end else begin
              state_q <= ST_CHECK;
            end
          end
        end
        ST_CHECK: begin
          if (DRV_DENSITY_IN != (mode2_q & dd_q)) begin
            est_q[ES_DENS_ERR] <= 1'b1; // see R8
            errcode_q          <= EC_DENSITY;
            err_set_q          <= 1'b1;
            state_q            <= ST_FINISH;
          end else begin
            drv_valid_q <= 1'b1;        // see R11
            drv_req_q   <= '{write: (func_q == FN_WRITE), dd: (mode2_q & dd_q), track: track_q, sector: sector_q};
            state_q     <= ST_FIND;
          end
        end
        ST_KEY_REQ: begin
          if (XFER_WR_IN) begin
            if (XFER_DATA_IN[7:0] == KEY_BYTE) begin
              init_q      <= 1'b1;      // see R20
              track_q     <= 7'h00;
              sector_q    <= FIRST_SECTOR;
              drv_valid_q <= 1'b1;
              drv_req_q   <= '{write: 1'b1, dd: dd_q, track: 7'h00, sector: FIRST_SECTOR};
              state_q     <= ST_FIND;
            end else begin
              errcode_q <= EC_KEY;      // see R19
              err_set_q <= 1'b1;
              state_q   <= ST_FINISH;
            end
          end
        end
        ST_FIND: begin
          if (DRV_ACK_IN) begin
            drv_valid_q <= 1'b0;
            cnt_q       <= 9'h000;
            crc_q       <= CRC_INIT;
            wr_valid_q  <= 1'b0;
            if (DRV_RESULT_IN == DRV_FOUND) begin
              state_q <= drv_req_q.write ? ST_WRITE : ST_READ;
            end else begin
              errcode_q <= (DRV_RESULT_IN == DRV_NOTFOUND && !init_q) ? EC_NOT_FOUND : EC_HEADER;  // see R12, R21
              err_set_q <= 1'b1;
              state_q   <= ST_FINISH;
            end
          end
        end
        ST_READ: begin
          if (DRV_RD_VALID_IN) begin
            crc_q <= crc_step(crc_q, DRV_RD_DATA_IN);  // see R14
            cnt_q <= cnt_q + 9'h001;
            if (cnt_q == 9'h000) begin
              est_q[ES_DELETED] <= DRV_RD_DELETED_IN;  // see R16
            end
            if (cnt_q == sect_bytes + 9'h002) begin
              state_q <= ST_RD_CHECK;
            end
          end
        end
        ST_RD_CHECK: begin
          if (crc_q != 16'h0000) begin
            est_q[ES_CRC_ERR] <= 1'b1;  // see R15
            errcode_q         <= EC_CRC;
            err_set_q         <= 1'b1;
          end
          state_q <= ST_FINISH;
        end
        ST_WRITE: begin
          if (!wr_valid_q) begin
            wr_data_q  <= wr_byte;      // see R9, R20
            wr_valid_q <= 1'b1;
          end else if (DRV_WR_READY_IN) begin
            wr_valid_q <= 1'b0;
            cnt_q      <= cnt_q + 9'h001;
            if (cnt_q < sect_bytes) begin
              crc_q <= crc_step(crc_q, wr_data_q);
            end
            if (cnt_q == sect_bytes + 9'h001) begin
              if (!init_q) begin
                state_q <= ST_FINISH;
              end else if (sector_q == LAST_SECTOR && track_q == LAST_TRACK) begin
                state_q <= ST_FINISH;   // see R21
              end else begin
                sector_q    <= (sector_q == LAST_SECTOR) ? FIRST_SECTOR : sector_q + 5'h01;
                track_q     <= (sector_q == LAST_SECTOR) ? track_q + 7'h01 : track_q;
                drv_req_q.sector <= (sector_q == LAST_SECTOR) ? FIRST_SECTOR : sector_q + 5'h01;
                drv_req_q.track  <= (sector_q == LAST_SECTOR) ? track_q + 7'h01 : track_q;
                drv_valid_q <= 1'b1;
                state_q     <= ST_FIND;
              end
            end
          end
        end
        ST_FINISH: begin
          iface_q    <= status_word;    // see R4, R17
          done_set_q <= 1'b1;           // see R17
          state_q    <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Host flags; a set in the same cycle as a test wins
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      treq_q  <= 1'b0;
      done_q  <= 1'b0;
      error_q <= 1'b0;
      int_q   <= 1'b0;
    end else begin
      treq_q  <= treq_set_q | (treq_q & ~TREQ_TEST_IN);  // see R1, R6
      done_q  <= done_set_q | (done_q & ~DONE_TEST_IN & ~LOAD_CMD_IN);  // see R22
      error_q <= err_set_q | (error_q & ~LOAD_CMD_IN);
      int_q   <= done_set_q & ie_q;  // see R5
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave; answers every access one cycle after the request
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
      mode2_q <= 1'b0;
      ie_q    <= 1'b0;
    end else begin
      ack_q <= WB_CYC_IN & WB_STB_IN & ~ack_q;
      if (WB_CYC_IN && WB_STB_IN && !ack_q) begin
        if (WB_WE_IN && WB_ADR_IN == REG_CTRL && WB_SEL_IN[0]) begin
          mode2_q <= WB_DAT_IN[CTRL_MODE2];
          ie_q    <= WB_DAT_IN[CTRL_IE];
        end
        case (WB_ADR_IN)
          REG_CTRL:    rdata_q <= {30'h0, ie_q, mode2_q};
          REG_FLAGS:   rdata_q <= {24'h0, 4'(state_q), 1'b0, error_q, done_q, treq_q};
          REG_ERRCODE: rdata_q <= {24'h0, errcode_q};
          REG_ESTAT:   rdata_q <= {20'h0, status_word};
          default:     rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign IFACE_WORD_OUT    = iface_q;
  assign TREQ_OUT          = treq_q;
  assign DONE_OUT          = done_q;
  assign ERROR_OUT         = error_q;
  assign INT_REQ_OUT       = int_q;
  assign DRV_REQ_VALID_OUT = drv_valid_q;
  assign DRV_REQ_OUT       = drv_req_q;
  assign DRV_WR_VALID_OUT  = wr_valid_q;
  assign DRV_WR_DATA_OUT   = wr_data_q;
  assign WB_DAT_OUT        = rdata_q;
  assign WB_ACK_OUT        = ack_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  treq_set_wins_a: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)  // see R1
    treq_set_q |=> treq_q) else $error("transfer request lost");
  buffer_kept_a: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)  // see R2
    buf_we |-> func_q == FN_READ && !drv_req_q.write) else $error("buffer written outside a read");
  done_after_status_a: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)  // see R17
    $rose(done_q) |-> $past(state_q, 2) == ST_FINISH && iface_q == $past(status_word, 2))
    else $error("done without status word");
  int_on_done_a: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)  // see R5
    int_q |-> done_q && $past(ie_q)) else $error("interrupt without done");
  track_check_a: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)  // see R11
    state_q == ST_TRK_REQ && XFER_WR_IN && XFER_DATA_IN > 12'h04c |=> errcode_q == 8'h20 ##2 error_q)
    else $error("illegal track not refused");
  not_found_a: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)  // see R12
    state_q == ST_FIND && DRV_ACK_IN && DRV_RESULT_IN == 2'h1 && !init_q |=> errcode_q == 8'h38)
    else $error("wrong code for missing sector");
  crc_fail_a: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)  // see R15
    state_q == ST_RD_CHECK && crc_q != 16'h0 |=> est_q[11] && errcode_q == 8'h80 ##1 error_q)
    else $error("CRC failure not reported");
  key_wrong_a: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)  // see R19
    state_q == ST_KEY_REQ && XFER_WR_IN && XFER_DATA_IN[7:0] != 8'h49 |=> errcode_q == 8'ha8 ##2 done_q)
    else $error("bad key accepted");
  empty_count_a: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)  // see R3
    state_q == ST_EB_WAIT |-> cnt_q < words) else $error("empty buffer overran its count");
  wb_ack_pulse_a: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
    WB_ACK_OUT |=> !WB_ACK_OUT) else $error("ack held");

endmodule

// file: sim/floppy_function_sequencer_test.sv
/*
  Self-checking bench for the function sequencer.
  Assumes the drive model and a classic Wishbone master driven here.
*/
module floppy_function_sequencer_test
  import fss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, ld, xwr, xrd, strt, sdnt, dens, rqv, ack, rdv, rddel, wrv, wrr, cyc, stb, we, wack, del_sel, bad_crc;
  logic treq, done, err, intr;
  logic [11:0] cmdw, xdat, iface;
  logic [1:0] res, res_sel;
  logic [7:0] rdd, wrd, adr, base;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  fss_drv_req_type rq;
  int n_mismatch, comparisons, n_int, cycles;
  fss_sequencer u_dut (.CLOCK_IN(clk), .RST_IN(rst), .LOAD_CMD_IN(ld), .CMD_WORD_IN(cmdw), .XFER_WR_IN(xwr),
    .XFER_RD_IN(xrd), .XFER_DATA_IN(xdat), .TREQ_TEST_IN(strt), .DONE_TEST_IN(sdnt), .IFACE_WORD_OUT(iface),
    .TREQ_OUT(treq), .DONE_OUT(done), .ERROR_OUT(err), .INT_REQ_OUT(intr), .DRV_DENSITY_IN(dens),
    .DRV_REQ_VALID_OUT(rqv), .DRV_REQ_OUT(rq), .DRV_ACK_IN(ack), .DRV_RESULT_IN(res), .DRV_RD_VALID_IN(rdv),
    .DRV_RD_DATA_IN(rdd), .DRV_RD_DELETED_IN(rddel), .DRV_WR_VALID_OUT(wrv), .DRV_WR_DATA_OUT(wrd),
    .DRV_WR_READY_IN(wrr), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
    .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(wack));
  fss_drive_model u_drv (.clk(clk), .rst(rst), .req_valid(rqv), .req(rq), .ack(ack), .result(res),
    .rd_valid(rdv), .rd_data(rdd), .rd_deleted(rddel), .wr_valid(wrv), .wr_data(wrd), .wr_ready(wrr),
    .res_sel(res_sel), .del_sel(del_sel), .bad_crc(bad_crc), .base(base));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk) if (intr === 1'b1) n_int++;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      test_done();
    end
  end
  function automatic logic [7:0] pat(input logic [7:0] b, input int i);
    return b + 8'(i * 3);
  endfunction
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int t = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do begin @(posedge clk); t++; end while (wack !== 1'b1 && t < 50);
    if (t >= 50) n_mismatch++;
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input int k, input logic [11:0] d);
    xdat <= d;
    cmdw <= d;
    case (k)
      0: ld <= 1'b1;
      1: xwr <= 1'b1;
      2: xrd <= 1'b1;
      3: strt <= 1'b1;
      default: sdnt <= 1'b1;
    endcase
    @(posedge clk);
    {ld, xwr, xrd, strt, sdnt} <= '0;
    @(posedge clk);
  endtask
  task automatic wait_flag(input bit d);
    int t = 0;
    while ((d ? done : treq) !== 1'b1 && t < 3000) begin @(posedge clk); t++; end
    check(32'(t < 3000), 32'h1);
  endtask
  task automatic start(input logic [2:0] f, input logic w8);
    pulse(4, 12'h0);
    check(done, 0);
    pulse(0, 12'({w8, 3'h0}) << CMD_W8_BIT - 3 | 12'(f) << CMD_FUNC_LSB);
  endtask
  task automatic give(input logic [11:0] w);
    wait_flag(0);
    pulse(3, 12'h0);
    check(treq, 0);
    pulse(1, w);
  endtask
  task automatic sector(input logic [2:0] f, input logic [6:0] t, input logic [4:0] s);
    start(f, 1'b1);
    give(12'(s));
    give(12'(t));
    wait_flag(1);
  endtask
  task automatic failed(input logic [7:0] code);
    logic [31:0] q;
    check(err, 1);
    wb(1'b0, REG_ERRCODE, 32'h0, q);
    check(q, 32'(code));
  endtask
  task automatic empty_chk(input bit w8);
    for (int r = 0; r < 2; r++) begin
      start(FN_EMPTY, w8);
      for (int i = 0; i < (w8 ? 128 : 64); i++) begin
        wait_flag(0);
        pulse(3, 12'h0);
        check(iface, pat(base, i));
        pulse(2, 12'h0);
      end
      wait_flag(1);
      pulse(2, 12'h0);
      check(iface, 0);
    end
  endtask
  initial begin
    logic [31:0] q;
    logic [15:0] c;
    logic [6:0]  trk;
    logic [4:0]  sec;
    {rst, ld, xwr, xrd, strt, sdnt, dens, cyc, stb, we, del_sel, bad_crc} = 12'h800;
    {cmdw, xdat, adr, base, res_sel, wdat, sel} = {42'h0, 32'h0, 4'hf};
    q = $urandom(28788);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({treq, done, err, intr}, 0);
    wb(1'b0, REG_CTRL, 32'h0, q);
    check(q, 0);
    wb(1'b1, 8'h10, 32'hffffffff, q);
    wb(1'b0, 8'h10, 32'h0, q);
    check(q, 0);
    base <= 8'($urandom);
    trk = 7'($urandom_range(0, 76));
    sec = 5'($urandom_range(1, 26));
    sector(FN_READ, trk, sec);
    check({err, iface}, 0);
    check(u_drv.seen_req, {2'b00, trk, sec});
    check(n_int, 0);
    empty_chk(1'b1);
    empty_chk(1'b0);
    wb(1'b1, REG_CTRL, 32'h2, q);
    n_int = 0;
    sector(FN_WRITE, trk, sec);
    check(u_drv.seen_req, {2'b10, trk, sec});
    c = CRC_INIT;
    for (int i = 0; i < 128; i++) begin
      check(u_drv.wr_q[i], pat(base, i));
      c = u_drv.crc_upd(c, pat(base, i));
    end
    check({u_drv.wr_q[128], u_drv.wr_q[129]}, c);
    check(n_int, 1);
    empty_chk(1'b1);
    del_sel <= 1'b1;
    sector(FN_READ, trk, sec);
    check(iface, 12'h020);
    {del_sel, bad_crc} <= 2'b01;
    sector(FN_READ, trk, sec);
    check(iface, 12'h800);
    failed(EC_CRC);
    {res_sel, bad_crc} <= {DRV_NOTFOUND, 1'b0};
    sector(FN_READ, trk, sec);
    failed(EC_NOT_FOUND);
    res_sel <= DRV_FOUND;
    sector(FN_READ, 7'h4d, sec);
    failed(EC_TRACK);
    dens <= 1'b1;
    sector(FN_READ, trk, sec);
    failed(EC_DENSITY);
    dens <= 1'b0;
    start(FN_DENSITY, 1'b1);
    wait_flag(1);
    check(treq, 0);
    wb(1'b1, REG_CTRL, 32'h3, q);
    start(FN_DENSITY, 1'b1);
    give(12'h04a);
    wait_flag(1);
    failed(EC_KEY);
    res_sel <= 2'h2;
    start(FN_DENSITY, 1'b1);
    give(12'(KEY_BYTE));
    wait_flag(1);
    failed(EC_HEADER);
    check({u_drv.seen_req.track, u_drv.seen_req.sector}, {7'h0, FIRST_SECTOR});
    test_done();
  end
endmodule

// file: sim/fss_drive_model.sv
/*
  Behavioural drive engine facing the function sequencer.
  Assumes one clock and requests held until acknowledged.
*/
module fss_drive_model
  import fss_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       req_valid,
  input  fss_drv_req_type req,
  output logic            ack,
  output logic [1:0]      result,
  output logic            rd_valid,
  output logic [7:0]      rd_data,
  output logic            rd_deleted,
  input  wire logic       wr_valid,
  input  wire logic [7:0] wr_data,
  output logic            wr_ready,
  input  wire logic [1:0] res_sel,
  input  wire logic       del_sel,
  input  wire logic       bad_crc,
  input  wire logic [7:0] base
);
  fss_drv_req_type seen_req;
  logic [7:0]      wr_q[$];
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    return c;
  endfunction
  initial begin
    logic [15:0] crc;
    logic [7:0]  v;
    int          n;
    {ack, result, rd_valid, rd_data, rd_deleted, wr_ready} = '0;
    forever begin
      @(posedge clk);
      if (!rst && req_valid) begin
        seen_req = req;
        wr_q.delete();
        n = req.dd ? 256 : 128;
        crc = CRC_INIT;
        repeat ($urandom_range(1, 6)) @(posedge clk);
        ack <= 1'b1;
        result <= res_sel;
        @(posedge clk);
        ack <= 1'b0;
        result <= ~res_sel;
        if (res_sel == DRV_FOUND && !req.write) begin
          // Mark, data and CRC stream; released lines carry the inverse.
          for (int i = 0; i < n + 3; i++) begin
            v = (i == 0) ? (del_sel ? 8'hf8 : 8'hfb) : (i <= n) ? base + 8'((i - 1) * 3)
              : (i == n + 1) ? crc[15:8] ^ {7'h0, bad_crc} : crc[7:0];
            if (i <= n) crc = crc_upd(crc, v);
            rd_valid <= 1'b1;
            rd_data <= v;
            rd_deleted <= del_sel;
            @(posedge clk);
            rd_valid <= 1'b0;
            rd_data <= ~v;
            @(posedge clk);
          end
        end else if (res_sel == DRV_FOUND) begin
          while (wr_q.size() < n + 2) begin
            @(posedge clk);
            if (wr_valid && wr_ready) wr_q.push_back(wr_data);
            wr_ready <= (wr_q.size() < n + 2) ? ~wr_ready : 1'b0;
          end
        end
      end
    end
  end
endmodule
